// ---- bit_test_pkg.sv ----
// Constants shared by the bit-test execution unit
//
// Summary of operation
// RULE1: File form stores the inverted selected memory bit into the zero flag.
// RULE2: File form never writes the addressed data-memory location.
// RULE3: Bits count from LSB 0; byte 0-7 at 0-8191, word 0-15 at even 0-8190.
// RULE4: Software gives word-aligned word addresses and byte bit numbers up to 7.
// RULE5: File form takes bit number from b fields, 13-bit address from f fields.
// RULE6: Immediate working form: zero variant stores inverted bit, carry variant true bit.
// RULE7: Working forms are word only; with no suffix they act on the zero flag.
// RULE8: One destination-select bit picks carry flag or zero flag.
// RULE9: Non-setting working tests leave the operand intact; all addressing modes allowed. The code rejects mode codes 6 and 7 as illegal.
// RULE10: Register-selected form uses only the low four bits of the select register.
// RULE11: Test-and-mark records the bit into its flag, then sets that operand bit.
// RULE12: p field picks the addressing mode, s field picks one of sixteen registers.
// RULE13: Each instruction finishes in one cycle and touches only its own flag.
// RULE14: Pre/post increment or decrement moves the pointer by two.
package bit_test_pkg;
    localparam int APB_AW = 16;
    localparam int INSTR_W = 24;
    localparam int WORD_W = 16;
    localparam int NUM_WREGS = 16;

    // Register map, byte addresses
    localparam logic [APB_AW-1:0] OFS_INSTR = 16'h0000;
    localparam logic [APB_AW-1:0] OFS_STATUS = 16'h0004;
    localparam logic [APB_AW-1:0] OFS_RESULT = 16'h0008;
    localparam logic [APB_AW-1:0] OFS_WREG_BASE = 16'h0040;
    localparam logic [APB_AW-1:0] OFS_WREG_LAST = 16'h007C;
    localparam logic [APB_AW-1:0] OFS_DMEM_BASE = 16'h4000;

    // Reset values
    localparam logic [INSTR_W-1:0] INSTR_RESET = 24'h000000;
    localparam logic [WORD_W-1:0] STATUS_RESET = 16'h0000;
    localparam logic [WORD_W-1:0] WREG_RESET = 16'h0000;

    // Status flag positions
    localparam int SR_C_BIT = 0;
    localparam int SR_Z_BIT = 1;

    // Result register fields
    localparam int RES_BIT_POS = 0;
    localparam int RES_ILLEGAL_POS = 1;

    // Instruction fields
    localparam int FLD_OPC_LSB = 16;
    localparam int FLD_IMM_LSB = 12;
    localparam int FLD_DST_IMM = 11;
    localparam int FLD_DST_REG = 15;
    localparam int FLD_WB_LSB = 11;
    localparam int FLD_MODE_LSB = 4;
    localparam int FLD_SREG_LSB = 0;
    localparam int FLD_FB_HI_LSB = 13;
    localparam int FLD_FADDR_LSB = 1;
    localparam int FLD_FB_LO = 0;

    localparam logic [7:0] OPC_FILE = 8'hAB;
    localparam logic [7:0] OPC_IMM = 8'hA3;
    localparam logic [7:0] OPC_MARK = 8'hA4;
    localparam logic [7:0] OPC_REGSEL = 8'hA5;

    // Source addressing modes
    localparam logic [2:0] AM_DIRECT = 3'h0;
    localparam logic [2:0] AM_IND = 3'h1;
    localparam logic [2:0] AM_POSTDEC = 3'h2;
    localparam logic [2:0] AM_POSTINC = 3'h3;
    localparam logic [2:0] AM_PREDEC = 3'h4;
    localparam logic [2:0] AM_PREINC = 3'h5;

    localparam logic [WORD_W-1:0] PTR_STEP = 16'h0002;
endpackage

// ---- bit_probe.sv ----
// Selects one bit of a word and forms the word with that bit set
`timescale 1ns/1ps
module bit_probe
    import bit_test_pkg::*;
(
    input wire logic [WORD_W-1:0] word_in,
    input wire logic [3:0] pos,
    output logic bit_out,
    output logic [WORD_W-1:0] marked
);
    always_comb
    begin
        bit_out = word_in[pos]; // [RULE3]
        marked = word_in | (16'h0001 << pos); // [RULE11]
    end
endmodule

// ---- bit_test_flag_unit.sv ----
// Bit-test execution unit with APB register access
//
// The APB register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
module bit_test_flag_unit
    import bit_test_pkg::*;
#(
    parameter int DMEM_WORDS = 4096
)
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [APB_AW-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic z_flag,
    output logic c_flag,
    output logic exec_done
);
    localparam int DIDX_W = $clog2(DMEM_WORDS);

    // Refused at elaboration: the index slices need a power-of-two depth
    if (DMEM_WORDS < 2 || DMEM_WORDS > 4096 || (DMEM_WORDS & (DMEM_WORDS - 1)) != 0)
    begin : g_depth_check
        $error("DMEM_WORDS must be a power of two from 2 to 4096");
    end

    // Reset release synchroniser
    logic rst_meta_reg;
    logic rst_sync_reg;
    logic rst_n;

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    assign rst_n = rst_sync_reg;

    // Storage
    logic [WORD_W-1:0] wreg_reg [NUM_WREGS];
    logic [WORD_W-1:0] dmem [DMEM_WORDS];
    logic [INSTR_W-1:0] instr_reg;
    logic [WORD_W-1:0] status_reg;
    logic [1:0] result_reg;
    logic exec_pend_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic [31:0] prdata_reg;
    logic exec_done_reg;

    function automatic logic [31:0] merge_lanes(input logic [31:0] old_val,
                                                input logic [31:0] new_val,
                                                input logic [3:0] strb);
        logic [31:0] res;
        res = old_val;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
                res[i*8 +: 8] = new_val[i*8 +: 8];
        end
        return res;
    endfunction

    function automatic logic [DIDX_W-1:0] word_index(input logic [WORD_W-1:0] byte_addr);
        return byte_addr[DIDX_W:1];
    endfunction

    // Bus decode
    logic acc_done;
    logic wr_done;
    logic sel_instr;
    logic sel_status;
    logic sel_result;
    logic sel_wreg;
    logic sel_dmem;
    logic mapped;
    logic [3:0] bus_wreg_idx;
    logic [DIDX_W-1:0] bus_dmem_idx;
    logic [APB_AW-1:0] dmem_end;

    assign acc_done = psel && penable && pready_reg;
    assign wr_done = acc_done && pwrite && mapped;
    assign dmem_end = 16'(int'(OFS_DMEM_BASE) + DMEM_WORDS * 4);

    always_comb
    begin
        sel_instr = 1'b0;
        sel_status = 1'b0;
        sel_result = 1'b0;
        sel_wreg = 1'b0;
        sel_dmem = 1'b0;
        if (paddr[1:0] != 2'b00)
            sel_instr = 1'b0;
        else if (paddr == OFS_INSTR)
        begin
            sel_instr = 1'b1;
        end
        else if (paddr == OFS_STATUS)
        begin
            sel_status = 1'b1;
        end
        else if (paddr == OFS_RESULT)
        begin
            sel_result = 1'b1;
        end
        else if (paddr >= OFS_WREG_BASE && paddr <= OFS_WREG_LAST)
        begin
            sel_wreg = 1'b1;
        end
        else if (paddr >= OFS_DMEM_BASE && paddr < dmem_end)
        begin
            sel_dmem = 1'b1;
        end
        mapped = sel_instr | sel_status | sel_result | sel_wreg | sel_dmem;
    end

    assign bus_wreg_idx = paddr[5:2];
    assign bus_dmem_idx = paddr[DIDX_W+1:2];

    // Instruction decode and operand fetch
    logic [7:0] opc;
    logic [2:0] mode;
    logic [3:0] sreg;
    logic [WORD_W-1:0] ptr;
    logic [WORD_W-1:0] ea;
    logic [WORD_W-1:0] ptr_new;
    logic [WORD_W-1:0] operand;
    logic [3:0] pos;
    logic to_z;
    logic do_mark;
    logic from_mem;
    logic ptr_upd;
    logic legal;
    logic tested;
    logic [WORD_W-1:0] marked;

    always_comb
    begin
        opc = instr_reg[FLD_OPC_LSB +: 8];
        mode = instr_reg[FLD_MODE_LSB +: 3]; // [RULE12]
        sreg = instr_reg[FLD_SREG_LSB +: 4]; // [RULE12]
        ptr = wreg_reg[sreg];
        ea = ptr;
        ptr_new = ptr;
        ptr_upd = 1'b0;
        from_mem = 1'b1;
        pos = instr_reg[FLD_IMM_LSB +: 4];
        to_z = instr_reg[FLD_DST_IMM]; // [RULE8]
        do_mark = 1'b0;
        legal = 1'b1;
        if (opc == OPC_FILE)
        begin
            // Instruction bit 0 becomes bit 0 of the bit number; the word address is always even
            pos = {instr_reg[FLD_FB_HI_LSB +: 3], instr_reg[FLD_FB_LO]}; // [RULE5] [RULE3]
            ea = {3'b000, instr_reg[FLD_FADDR_LSB +: 12], 1'b0}; // [RULE5] [RULE4]
            to_z = 1'b1; // [RULE1]
        end
        else if (opc == OPC_IMM || opc == OPC_MARK || opc == OPC_REGSEL)
        begin
            if (opc == OPC_REGSEL)
            begin
                pos = wreg_reg[instr_reg[FLD_WB_LSB +: 4]][3:0]; // [RULE10]
                to_z = instr_reg[FLD_DST_REG]; // [RULE8]
            end
            do_mark = (opc == OPC_MARK); // [RULE11]
            case (mode)
                AM_DIRECT: from_mem = 1'b0;
                AM_IND: ea = ptr;
                AM_POSTDEC:
                begin
                    ptr_new = ptr - PTR_STEP; // [RULE14]
                    ptr_upd = 1'b1;
                end
                AM_POSTINC:
                begin
                    ptr_new = ptr + PTR_STEP; // [RULE14]
                    ptr_upd = 1'b1;
                end
                AM_PREDEC:
                begin
                    ea = ptr - PTR_STEP; // [RULE14]
                    ptr_new = ea;
                    ptr_upd = 1'b1;
                end
                AM_PREINC:
                begin
                    ea = ptr + PTR_STEP; // [RULE14]
                    ptr_new = ea;
                    ptr_upd = 1'b1;
                end
                default: legal = 1'b0;
            endcase
            // Word only: the low address bit is dropped, never a byte lane
            ea[0] = 1'b0; // [RULE7]
        end
        else
        begin
            legal = 1'b0;
        end
        operand = from_mem ? dmem[word_index(ea)] : ptr; // [RULE9]
    end

    bit_probe u_probe (
        .word_in(operand),
        .pos(pos),
        .bit_out(tested),
        .marked(marked)
    );

    logic exec_now;
    assign exec_now = exec_pend_reg && legal;

    // Bus handshake: one wait state, held off while an instruction runs
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h00000000;
        end
        else
        begin
            pready_reg <= psel && penable && !pready_reg && !exec_pend_reg;
            pslverr_reg <= psel && penable && !pready_reg && !exec_pend_reg && !mapped;
            if (psel && penable && !pready_reg)
            begin
                if (sel_instr)
                begin
                    prdata_reg <= {8'h00, instr_reg};
                end
                else if (sel_status)
                begin
                    prdata_reg <= {16'h0000, status_reg};
                end
                else if (sel_result)
                begin
                    prdata_reg <= {30'h00000000, result_reg};
                end
                else if (sel_wreg)
                begin
                    prdata_reg <= {16'h0000, wreg_reg[bus_wreg_idx]};
                end
                else if (sel_dmem)
                begin
                    prdata_reg <= {16'h0000, dmem[bus_dmem_idx]};
                end
                else
                begin
                    prdata_reg <= 32'h00000000;
                end
            end
        end
    end

    // Instruction issue; executes in the cycle after the write
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            instr_reg <= INSTR_RESET;
            exec_pend_reg <= 1'b0;
            exec_done_reg <= 1'b0;
        end
        else
        begin
            exec_pend_reg <= wr_done && sel_instr; // [RULE13]
            exec_done_reg <= exec_pend_reg;
            if (wr_done && sel_instr)
            begin
                instr_reg <= INSTR_W'(merge_lanes({8'h00, instr_reg}, pwdata, pstrb));
            end
        end
    end

    // Status flags: an instruction moves only its one destination flag
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            status_reg <= STATUS_RESET;
            result_reg <= 2'b00;
        end
        else
        begin
            if (exec_now)
            begin
                if (to_z)
                begin
                    status_reg[SR_Z_BIT] <= !tested; // [RULE1] [RULE6] [RULE11] [RULE13]
                end
                else
                begin
                    status_reg[SR_C_BIT] <= tested; // [RULE6] [RULE11] [RULE13]
                end
            end
            else if (wr_done && sel_status)
            begin
                status_reg <= WORD_W'(merge_lanes({16'h0000, status_reg}, pwdata, pstrb));
            end
            if (exec_pend_reg)
            begin
                result_reg[RES_BIT_POS] <= legal && tested;
                result_reg[RES_ILLEGAL_POS] <= !legal;
            end
        end
    end

    // Working registers: marked direct operand or adjusted pointer
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < NUM_WREGS; i++)
                wreg_reg[i] <= WREG_RESET;
        end
        else if (exec_now && do_mark && !from_mem)
        begin
            wreg_reg[sreg] <= marked; // [RULE11]
        end
        else if (exec_now && ptr_upd)
        begin
            wreg_reg[sreg] <= ptr_new; // [RULE14]
        end
        else if (wr_done && sel_wreg)
        begin
            wreg_reg[bus_wreg_idx] <=
                WORD_W'(merge_lanes({16'h0000, wreg_reg[bus_wreg_idx]}, pwdata, pstrb));
        end
    end

    // Data memory is written by the marking form and over the bus; the tests only read it
    always_ff @(posedge core_clk)
    begin
        if (exec_now && do_mark && from_mem)
        begin
            dmem[word_index(ea)] <= marked; // [RULE11] [RULE2] [RULE9]
        end
        else if (wr_done && sel_dmem)
        begin
            dmem[bus_dmem_idx] <=
                WORD_W'(merge_lanes({16'h0000, dmem[bus_dmem_idx]}, pwdata, pstrb));
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign z_flag = status_reg[SR_Z_BIT];
    assign c_flag = status_reg[SR_C_BIT];
    assign exec_done = exec_done_reg;
endmodule

// ---- bit_test_flag_unit_props.sv ----
// Port-level assertions for the bit-test unit
`timescale 1ns/1ps
module bit_test_flag_unit_props
    import bit_test_pkg::*;
#(
    parameter int DMEM_WORDS = 4096
)
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [APB_AW-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic z_flag,
    input wire logic c_flag,
    input wire logic exec_done
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    logic done_xfer;
    logic iw;
    logic stwr;
    assign done_xfer = psel && penable && pready && !pslverr;
    assign iw = done_xfer && pwrite && paddr == OFS_INSTR;
    assign stwr = done_xfer && pwrite && paddr == OFS_STATUS;
    a_ready_bound: assert property (psel && penable && !pready |-> ##[1:2] pready)
        else $error("access phase too long");
    a_done_timing: assert property (iw |-> ##2 exec_done)
        else $error("execution not done in time");
    a_done_pulse: assert property (exec_done |=> !exec_done)
        else $error("done pulse too long");
    a_one_flag: assert property (exec_done |-> !($changed(z_flag) && $changed(c_flag)))
        else $error("both flags changed");
    a_flag_cause: assert property ($changed(z_flag) || $changed(c_flag)
        |-> exec_done || $past(stwr))
        else $error("flag changed without cause");
    a_file_keeps_carry: assert property (iw && pwdata[23:16] == OPC_FILE |-> ##2 $stable(c_flag))
        else $error("file test touched carry");
    a_regsel_dst: assert property (iw && pwdata[23:16] == OPC_REGSEL && pwdata[15]
        |-> ##2 $stable(c_flag))
        else $error("zero destination touched carry");
    a_imm_carry_dst: assert property (iw && pwdata[23:16] == OPC_IMM && !pwdata[11]
        |-> ##2 $stable(z_flag))
        else $error("carry destination touched zero");
    a_status_view: assert property (done_xfer && !pwrite && paddr == OFS_STATUS
        |-> prdata[1:0] == {z_flag, c_flag})
        else $error("status read differs from flags");
    a_word_only: assert property (done_xfer && !pwrite && paddr >= OFS_WREG_BASE
        |-> prdata[31:16] == 16'h0000)
        else $error("upper half of word read not zero");
    a_err_data: assert property (pslverr |-> pready && prdata == 32'h00000000)
        else $error("error response carries data");
endmodule

// ---- bit_test_flag_unit_tb.sv ----
// Self-checking bench for the bit-test unit over APB
`timescale 1ns/1ps
module bit_test_flag_unit_tb
    import bit_test_pkg::*;
;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h00000000;
    logic [3:0] pstrb = 4'hF;
    logic [31:0] prdata;
    logic pready, pslverr, z_flag, c_flag, exec_done;
    int n_mismatch = 0;
    int n_checks = 0;
    logic [65:0] q[$];
    logic [65:0] ent;
    logic [15:0] w[16];
    logic [15:0] mem[16];

    always #12.5 core_clk = ~core_clk;

    // Small memory keeps pointer ranges and the edge of the map easy to reach
    bit_test_flag_unit #(.DMEM_WORDS(16)) dut (.core_clk(core_clk), .nrst(nrst),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .z_flag(z_flag), .c_flag(c_flag), .exec_done(exec_done));

    task close_out;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task check(input logic [32:0] seen, input logic [32:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Note carries {pslverr, prdata} expected and a compare mask
    task apb(input logic wr, input logic [15:0] a, input logic [31:0] d,
        input logic [32:0] e, input logic [32:0] m);
        int i;
        q.push_back({e, m});
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++)
        begin
            @(posedge core_clk);
            if (pready === 1'b1)
                break;
        end
        psel <= 1'b0;
        penable <= 1'b0;
        if (i == 20)
        begin
            n_mismatch++;
            close_out();
        end
        @(posedge core_clk);
    endtask

    task wr(input logic [15:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 33'h0, {1'b1, 32'h0});
    endtask

    task rd(input logic [15:0] a, input logic [32:0] e);
        apb(1'b0, a, 32'h0, e, {33{1'b1}});
    endtask

    task exec(input logic [23:0] ins);
        int i;
        wr(OFS_INSTR, {8'h00, ins});
        for (i = 0; i < 8; i++)
        begin
            @(posedge core_clk);
            if (exec_done === 1'b1)
                break;
        end
        if (i == 8)
        begin
            n_mismatch++;
            close_out();
        end
    endtask

    // Illegal forms must leave every flag alone and raise the result error bit
    task bad(input logic [23:0] ins);
        wr(OFS_STATUS, 32'h00005A5A);
        exec(ins);
        rd(OFS_STATUS, 33'h5A5A);
        apb(1'b0, OFS_RESULT, 32'h0, 33'h2, 33'h1FFFFFFFE);
    endtask

    always @(posedge core_clk)
    begin
        if (psel && penable && pready === 1'b1 && q.size() > 0)
        begin
            ent = q.pop_front();
            check({pslverr, prdata} & ent[32:0], ent[65:33] & ent[32:0]);
        end
    end

    initial
    begin
        int k, it;
        logic [3:0] s, sl, b, bp;
        logic [2:0] md;
        logic [1:0] op;
        logic dst, bt, zf, cf;
        logic [15:0] st, a;
        logic [23:0] ins;
        void'($urandom(60));
        repeat (16) @(posedge core_clk);
        nrst <= 1'b1;
        repeat (3) @(posedge core_clk);
        rd(OFS_STATUS, 33'h0);
        for (k = 0; k < 16; k++)
        begin
            w[k] = 16'h0000;
            mem[k] = 16'($urandom);
            rd(OFS_WREG_BASE + 16'(4 * k), 33'h0);
            wr(OFS_DMEM_BASE + 16'(4 * k), {16'h0000, mem[k]});
        end
        $display("test reset_values done");
        for (it = 0; it < 80; it++)
        begin
            op = 2'($urandom % 4);
            s = 4'($urandom);
            sl = 4'($urandom);
            b = 4'($urandom);
            md = 3'($urandom % 6);
            dst = 1'($urandom);
            k = $urandom % 16;
            st = 16'($urandom);
            // Pointers stay inside the small memory after any step of two
            w[s] = (md != 0) ? 16'(2 + 2 * ($urandom % 14)) : 16'($urandom);
            if (sl != s)
                w[sl] = 16'($urandom);
            wr(OFS_WREG_BASE + 16'(4 * s), {16'h0000, w[s]});
            wr(OFS_WREG_BASE + 16'(4 * sl), {16'h0000, w[sl]});
            wr(OFS_STATUS, {16'h0000, st});
            zf = st[1];
            cf = st[0];
            bp = (op == 3) ? w[sl][3:0] : b;
            a = w[s];
            if (op == 0)
            begin
                bt = mem[k][b];
                zf = ~bt;
                ins = {OPC_FILE, b[3:1], 12'(k), b[0]};
            end
            else
            begin
                if (md == 4)
                    a = a - 16'h2;
                if (md == 5)
                    a = a + 16'h2;
                if (md != 0)
                    w[s] = (md == 2) ? a - 16'h2 : (md == 3) ? a + 16'h2 : a;
                if (md != 0)
                    k = int'(a[4:1]);
                bt = (md == 0) ? a[bp] : mem[k][bp];
                if (op == 2 && md == 0)
                    w[s][bp] = 1'b1;
                if (op == 2 && md != 0)
                    mem[k][bp] = 1'b1;
                if (dst)
                    zf = ~bt;
                else
                    cf = bt;
                ins = (op == 3) ? {OPC_REGSEL, dst, sl, 4'h0, md, s}
                    : {((op == 1) ? OPC_IMM : OPC_MARK), b, dst, 4'h0, md, s};
            end
            exec(ins);
            rd(OFS_STATUS, {17'h0, st[15:2], zf, cf});
            rd(OFS_RESULT, {32'h0, bt});
            rd(OFS_WREG_BASE + 16'(4 * s), {17'h0, w[s]});
            rd(OFS_DMEM_BASE + 16'(4 * k), {17'h0, mem[k]});
        end
        $display("test random_bit_tests done");
        bad({OPC_IMM, 4'h3, 1'b1, 4'h0, 3'h6, 4'h2});
        bad({OPC_MARK, 4'h3, 1'b0, 4'h0, 3'h7, 4'h2});
        bad(24'h000000);
        $display("test illegal_forms done");
        rd(16'h0010, {1'b1, 32'h0});
        apb(1'b1, 16'h0045, 32'h00001234, {1'b1, 32'h0}, {1'b1, 32'h0});
        rd(OFS_WREG_BASE + 16'h0004, {17'h0, w[1]});
        rd(OFS_DMEM_BASE + 16'h0040, {1'b1, 32'h0});
        // One lane only: the upper byte of the working register must survive
        pstrb <= 4'h1;
        wr(OFS_WREG_BASE + 16'h0008, 32'h0000BEEF);
        pstrb <= 4'hF;
        rd(OFS_WREG_BASE + 16'h0008, {17'h0, w[2][15:8], 8'hEF});
        $display("test bus_errors done");
        close_out();
    end
endmodule

bind bit_test_flag_unit bit_test_flag_unit_props #(.DMEM_WORDS(DMEM_WORDS)) u_props (
    .core_clk(core_clk), .nrst(nrst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .z_flag(z_flag), .c_flag(c_flag), .exec_done(exec_done));
